// ---- core/sram_ctrl_defs.vh ----
// Purpose: Constants for the asynchronous SRAM host controller
// Assumes: 100 MHz system clock, 10 ns speed grade of the memory
// Notes: Times in ns or us, cycle counts derived from them
`ifndef SRAM_CTRL_DEFS_VH
`define SRAM_CTRL_DEFS_VH

`define CLK_PERIOD_NS 10
`define ADDR_W 21
`define DATA_W 8

// Timing figures as printed
`define DATA_SETUP_TO_WRITE_END_NS 6
`define DATA_HOLD_AFTER_WRITE_END_NS 0
`define ADDRESS_SETUP_TO_WRITE_END_NS 8
`define ADDRESS_HOLD_AFTER_WRITE_END_NS 0
`define WRITE_PULSE_MIN_OUTPUTS_OFF_NS 8
`define WRITE_PULSE_MIN_OUTPUTS_ON_NS 10
`define STROBE_TO_FLOAT_DELAY_NS 4
`define OUTPUT_DISABLE_TO_FLOAT_DELAY_NS 5
`define ACCESS_CYCLE_NS 10
`define POWER_UP_WAIT_US 150

// Cycle counts, least times rounded up
`define CDIV_UP(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FLOAT_CYC `CDIV_UP(`STROBE_TO_FLOAT_DELAY_NS)
`define SETUP_CYC `CDIV_UP(`DATA_SETUP_TO_WRITE_END_NS)
`define PULSE_CYC `CDIV_UP(`WRITE_PULSE_MIN_OUTPUTS_ON_NS)
`define ODIS_CYC `CDIV_UP(`OUTPUT_DISABLE_TO_FLOAT_DELAY_NS)
`define ACCESS_CYC `CDIV_UP(`ACCESS_CYCLE_NS)
`define POWER_UP_CYC (`POWER_UP_WAIT_US * 1000 / `CLK_PERIOD_NS)

`endif

// ---- core/cycle_timer.v ----
// Purpose: Down counter that flags when a loaded wait has elapsed
// Assumes: Load and enable from the same clock domain
// Notes: done_out is high while the count is zero
`timescale 1ns/10ps
`default_nettype none
module cycle_timer #(
	parameter W = 16
) (
	input wire sys_clk_in,
	input wire reset_in,
	input wire ce_in,
	input wire load_in,
	input wire [W-1:0] value_in,
	output wire done_out
);
	reg [W-1:0] count_q;
	always @(posedge sys_clk_in) begin
		if (reset_in) begin
			count_q <= {W{1'b0}};
		end else if (ce_in) begin
			if (load_in) begin
				count_q <= value_in;
			end else if (count_q != {W{1'b0}}) begin
				count_q <= count_q - {{(W-1){1'b0}}, 1'b1};
			end
		end
	end
	assign done_out = (count_q == {W{1'b0}});
endmodule // cycle_timer
`default_nettype wire

// ---- core/sram_host_ctrl.v ----
// Purpose: Host controller driving a 2M x 8 asynchronous SRAM over its pins
// Assumes: One request at a time, held until accepted by ready_out
// Notes: Writes are write-strobe terminated; reads are chip-select controlled
//
// Operation
// - Write happens only while select, byte controls and strobe all active.
// - Data setup and hold are timed against the write-ending edge.
// - Data stable 6 ns before write end, may change after it.
// - Address valid 8 ns before write end, held after it.
// - Strobe low at least 8 ns, or 10 ns with output enable low.
// - With output enable low, write lasts float delay plus data setup.
// - Our data drivers stay off while memory lines still drive.
// - Read address valid no later than chip select falling.
// - Wait 150 us after power before any access.
`timescale 1ns/10ps
`default_nettype none
`include "sram_ctrl_defs.vh"
module sram_host_ctrl #(
	parameter POWER_UP_CYCLES = `POWER_UP_CYC
) (
	input wire sys_clk_in,
	input wire reset_in,
	input wire ce_in,
	input wire req_in,
	input wire write_in,
	input wire keep_oe_in,
	input wire [`ADDR_W-1:0] addr_in,
	input wire [`DATA_W-1:0] wdata_in,
	output reg ready_out,
	output reg rdata_valid_out,
	output reg [`DATA_W-1:0] rdata_out,
	output reg [`ADDR_W-1:0] mem_addr_out,
	output reg select_low_active_n_out,
	output reg select_high_active_out,
	output reg upper_byte_n_out,
	output reg lower_byte_n_out,
	output reg write_n_out,
	output reg output_enable_n_out,
	output reg [`DATA_W-1:0] mem_data_out,
	output reg mem_data_oe_n_out,
	input wire [`DATA_W-1:0] mem_data_in
);
	// ------------------------------------------------------------
	// States
	// ------------------------------------------------------------
	localparam [3:0] ST_POWERUP = 4'h0;
	localparam [3:0] ST_IDLE = 4'h1;
	localparam [3:0] ST_W_FLOAT = 4'h2;
	localparam [3:0] ST_W_PULSE = 4'h3;
	localparam [3:0] ST_W_END = 4'h4;
	localparam [3:0] ST_R_SEL = 4'h5;
	localparam [3:0] ST_R_WAIT = 4'h6;
	localparam [3:0] ST_R_DONE = 4'h7;
	localparam [3:0] ST_R_FLOAT = 4'h8;
	localparam TW = 15;
	localparam integer FLOAT_I = `FLOAT_CYC;
	localparam integer PULSE_I = `PULSE_CYC;
	localparam integer ODIS_I = `ODIS_CYC;
	localparam integer ACCESS_I = `ACCESS_CYC;
	localparam integer PWR_I = POWER_UP_CYCLES;
	localparam [TW-1:0] FLOAT_C = FLOAT_I[TW-1:0];
	localparam [TW-1:0] PULSE_C = PULSE_I[TW-1:0];
	localparam [TW-1:0] ODIS_C = ODIS_I[TW-1:0];
	localparam [TW-1:0] ACCESS_C = ACCESS_I[TW-1:0];
	localparam [TW-1:0] PWR_C = PWR_I[TW-1:0];

	// ------------------------------------------------------------
	// Pin input synchroniser
	// ------------------------------------------------------------
	reg [`DATA_W-1:0] din_meta_q;
	reg [`DATA_W-1:0] din_sync_q;
	always @(posedge sys_clk_in) begin
		if (reset_in) begin
			din_meta_q <= {`DATA_W{1'b0}};
			din_sync_q <= {`DATA_W{1'b0}};
		end else if (ce_in) begin
			din_meta_q <= mem_data_in;
			din_sync_q <= din_meta_q;
		end
	end

	// ------------------------------------------------------------
	// Wait timer
	// ------------------------------------------------------------
	reg [3:0] state_q;
	reg tload_q;
	reg [TW-1:0] tval_q;
	reg pwr_started_q;
	reg keep_oe_q;
	wire tdone;
	wire twait;
	cycle_timer #(.W(TW)) u_timer (
		.sys_clk_in(sys_clk_in),
		.reset_in(reset_in),
		.ce_in(ce_in),
		.load_in(tload_q),
		.value_in(tval_q),
		.done_out(tdone)
	);
	assign twait = tload_q | ~tdone;

	// ------------------------------------------------------------
	// Access sequencer
	// ------------------------------------------------------------
	always @(posedge sys_clk_in) begin
		if (reset_in) begin
			state_q <= ST_POWERUP;
			tload_q <= 1'b0;
			tval_q <= {TW{1'b0}};
			pwr_started_q <= 1'b0;
			keep_oe_q <= 1'b0;
			ready_out <= 1'b0;
			rdata_valid_out <= 1'b0;
			rdata_out <= {`DATA_W{1'b0}};
			mem_addr_out <= {`ADDR_W{1'b0}};
			select_low_active_n_out <= 1'b1;
			select_high_active_out <= 1'b0;
			upper_byte_n_out <= 1'b1;
			lower_byte_n_out <= 1'b1;
			write_n_out <= 1'b1;
			output_enable_n_out <= 1'b1;
			mem_data_out <= {`DATA_W{1'b0}};
			mem_data_oe_n_out <= 1'b1;
		end else if (ce_in) begin
			tload_q <= 1'b0;
			rdata_valid_out <= 1'b0;
			case (state_q)
				ST_POWERUP: begin
					if (!pwr_started_q) begin
						pwr_started_q <= 1'b1;
						tload_q <= 1'b1;
						tval_q <= PWR_C;
					end else if (!twait) begin
						state_q <= ST_IDLE;
						ready_out <= 1'b1;
					end
				end
				ST_IDLE: begin
					if (req_in && ready_out) begin
						ready_out <= 1'b0;
						mem_addr_out <= addr_in;
						keep_oe_q <= keep_oe_in;
						if (write_in) begin
							mem_data_out <= wdata_in;
							// Select and strobe fall together, on the same edge as the address
							select_low_active_n_out <= 1'b0;
							select_high_active_out <= 1'b1;
							upper_byte_n_out <= 1'b0;
							lower_byte_n_out <= 1'b0;
							write_n_out <= 1'b0;
							output_enable_n_out <= ~keep_oe_in;
							tload_q <= 1'b1;
							// Old read data may still drive the bus
							tval_q <= keep_oe_in ? FLOAT_C : {TW{1'b0}};
							state_q <= ST_W_FLOAT;
						end else begin
							// Address goes out one cycle before select
							state_q <= ST_R_SEL;
						end
					end
				end
				ST_W_FLOAT: begin
					if (!twait) begin
						mem_data_oe_n_out <= 1'b0;
						tload_q <= 1'b1;
						// Pulse covers float plus setup and the minimum width
						tval_q <= (keep_oe_q ? PULSE_C : ACCESS_C) - FLOAT_C;
						state_q <= ST_W_PULSE;
					end
				end
				ST_W_PULSE: begin
					if (!twait) begin
						// Data has stood two edges or more, well over its setup
						write_n_out <= 1'b1;
						select_low_active_n_out <= 1'b1;
						select_high_active_out <= 1'b0;
						upper_byte_n_out <= 1'b1;
						lower_byte_n_out <= 1'b1;
						// Output enable up with the strobe, memory cannot drive into our data
						output_enable_n_out <= 1'b1;
						state_q <= ST_W_END;
					end
				end
				ST_W_END: begin
					// Drivers off one edge after write end, address held
					mem_data_oe_n_out <= 1'b1;
					output_enable_n_out <= 1'b1;
					state_q <= ST_IDLE;
					ready_out <= 1'b1;
				end
				ST_R_SEL: begin
					select_low_active_n_out <= 1'b0;
					select_high_active_out <= 1'b1;
					upper_byte_n_out <= 1'b0;
					lower_byte_n_out <= 1'b0;
					output_enable_n_out <= 1'b0;
					tload_q <= 1'b1;
					tval_q <= ACCESS_C;
					state_q <= ST_R_WAIT;
				end
				ST_R_WAIT: begin
					if (!twait) begin
						state_q <= ST_R_DONE;
					end
				end
				ST_R_DONE: begin
					// Synchroniser delay means sampled data is from the access
					rdata_out <= din_sync_q;
					rdata_valid_out <= 1'b1;
					select_low_active_n_out <= ~keep_oe_q;
					select_high_active_out <= keep_oe_q;
					upper_byte_n_out <= ~keep_oe_q;
					lower_byte_n_out <= ~keep_oe_q;
					output_enable_n_out <= ~keep_oe_q;
					tload_q <= 1'b1;
					tval_q <= ODIS_C;
					state_q <= ST_R_FLOAT;
				end
				ST_R_FLOAT: begin
					// Bus free after output disable float time, unless keep_oe_q left select and output enable low
					if (!twait) begin
						state_q <= ST_IDLE;
						ready_out <= 1'b1;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end
endmodule // sram_host_ctrl
`default_nettype wire

// ---- verification/sram_host_ctrl_monitor.sv ----
// Purpose: Pin timing checks for the SRAM host controller
// Assumes: ce_in held high
// Notes: Bound to every controller
`timescale 1ns/10ps
`default_nettype none
`include "sram_ctrl_defs.vh"
module sram_host_ctrl_monitor #(
	parameter POWER_UP_CYCLES = 4
) (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic ready_out,
	input wire logic rdata_valid_out,
	input wire logic [`ADDR_W-1:0] mem_addr_out,
	input wire logic select_low_active_n_out,
	input wire logic select_high_active_out,
	input wire logic upper_byte_n_out,
	input wire logic lower_byte_n_out,
	input wire logic write_n_out,
	input wire logic output_enable_n_out,
	input wire logic [`DATA_W-1:0] mem_data_out,
	input wire logic mem_data_oe_n_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);
	logic [15:0] up_q;
	always @(posedge sys_clk_in) begin
		up_q <= reset_in ? 16'h0000 : (&up_q ? up_q : up_q + 16'h0001);
	end
	AST_WRITE_OVERLAP: assert property (!write_n_out |-> !select_low_active_n_out &&
		select_high_active_out && !upper_byte_n_out && !lower_byte_n_out) else $error("strobe alone");
	AST_TURNAROUND: assert property ($fell(write_n_out) |-> mem_data_oe_n_out[*2] ##[1:2]
		(!mem_data_oe_n_out && !write_n_out)) else $error("bad turnaround");
	AST_WRITE_END_OE: assert property ($rose(write_n_out) |-> output_enable_n_out)
		else $error("output enable low at write end");
	AST_PULSE: assert property ($fell(write_n_out) |-> !write_n_out[*2]) else $error("short");
	AST_DATA_SETUP: assert property ($rose(write_n_out) |-> !mem_data_oe_n_out &&
		$past(!mem_data_oe_n_out) && $stable(mem_data_out)) else $error("data setup");
	AST_ADDR_SETUP: assert property ($rose(write_n_out) |-> $stable(mem_addr_out))
		else $error("address setup");
	AST_READ_ADDR: assert property ($fell(select_low_active_n_out) && write_n_out
		|-> $stable(mem_addr_out)) else $error("read address late");
	AST_HOLD_CYCLE: assert property ($fell(select_low_active_n_out) |=>
		!select_low_active_n_out) else $error("access too short");
	AST_POWER_UP: assert property (ready_out |-> up_q >= POWER_UP_CYCLES)
		else $error("early ready");
	cover property ($fell(write_n_out) && !output_enable_n_out);
	cover property ($fell(write_n_out) && output_enable_n_out);
	cover property (rdata_valid_out);
endmodule // sram_host_ctrl_monitor
bind sram_host_ctrl sram_host_ctrl_monitor #(.POWER_UP_CYCLES(POWER_UP_CYCLES)) u_mon (.*);
`default_nettype wire

// ---- verification/async_sram_model.sv ----
// Purpose: Behavioural byte-wide asynchronous SRAM
// Assumes: Sparse contents
// Notes: Released lines show inverted last value
`timescale 1ns/10ps
`default_nettype none
module async_sram_model (
	input wire logic [20:0] addr_in,
	input wire logic sel_n_in,
	input wire logic sel_in,
	input wire logic ub_n_in,
	input wire logic lb_n_in,
	input wire logic we_n_in,
	input wire logic oe_n_in,
	input wire logic [7:0] bus_in,
	output logic [7:0] dout_out,
	output logic drive_out
);
	logic [7:0] mem [int];
	logic [7:0] rd;
	logic [7:0] last;
	wire sel = !sel_n_in && sel_in;
	assign #2 drive_out = sel && we_n_in && !oe_n_in;
	always @(addr_in or sel or we_n_in or ub_n_in or lb_n_in or bus_in or drive_out) begin
		if (sel && !we_n_in && !ub_n_in && !lb_n_in) mem[addr_in] = bus_in;
		rd = mem.exists(addr_in) ? mem[addr_in] : 8'hA5;
		if (drive_out) last = rd;
	end
	assign dout_out = drive_out ? rd : ~last;
endmodule // async_sram_model
`default_nettype wire

// ---- verification/sram_host_ctrl_tb_top.sv ----
// Purpose: Write and read-back bench for the SRAM host controller
// Assumes: Short power-up wait
// Notes: Reads checked against a scoreboard queue
`timescale 1ns/10ps
`default_nettype none
module sram_host_ctrl_tb_top;
	logic sys_clk_in = 0, reset_in = 1, req_in = 0, write_in = 0, keep_oe_in = 0;
	logic [20:0] addr_in = 0;
	logic [7:0] wdata_in = 0;
	wire logic ready_out, rdata_valid_out, sl_n, sh, ub_n, lb_n, we_n, oe_n, d_oe_n, dev_drv;
	wire logic [7:0] rdata_out, mem_data_out, dev_d, bus;
	wire logic [20:0] mem_addr_out;
	int mismatches = 0, samples_checked = 0;
	logic [7:0] exp_q [$];
	logic [7:0] ref_m [int];
	always #5 sys_clk_in = ~sys_clk_in;
	assign bus = !d_oe_n ? mem_data_out : dev_d;
	sram_host_ctrl #(.POWER_UP_CYCLES(4)) u_sram_host_ctrl (.sys_clk_in(sys_clk_in),
		.reset_in(reset_in), .ce_in(1'b1), .req_in(req_in), .write_in(write_in),
		.keep_oe_in(keep_oe_in), .addr_in(addr_in), .wdata_in(wdata_in), .ready_out(ready_out),
		.rdata_valid_out(rdata_valid_out), .rdata_out(rdata_out), .mem_addr_out(mem_addr_out),
		.select_low_active_n_out(sl_n), .select_high_active_out(sh), .upper_byte_n_out(ub_n),
		.lower_byte_n_out(lb_n), .write_n_out(we_n), .output_enable_n_out(oe_n),
		.mem_data_out(mem_data_out), .mem_data_oe_n_out(d_oe_n), .mem_data_in(bus));
	async_sram_model u_async_sram_model (.addr_in(mem_addr_out), .sel_n_in(sl_n), .sel_in(sh),
		.ub_n_in(ub_n), .lb_n_in(lb_n), .we_n_in(we_n), .oe_n_in(oe_n), .bus_in(bus),
		.dout_out(dev_d), .drive_out(dev_drv));
	// ----------------------------------------
	// Checking
	// ----------------------------------------
	task check(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	always @(posedge sys_clk_in) if (rdata_valid_out === 1'b1) begin
		check(rdata_out, exp_q.size() ? exp_q.pop_front() : 8'hXX);
	end
	always @(negedge sys_clk_in) if (d_oe_n === 1'b0) check({7'h00, dev_drv}, 8'h00);
	task give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	task access(input logic w, input logic k, input logic [20:0] a, input logic [7:0] d);
		int n;
		n = 0;
		while (ready_out !== 1'b1 && n < 300) begin
			@(posedge sys_clk_in);
			#1;
			n++;
		end
		if (n >= 300) check(8'h00, 8'h01);
		@(posedge sys_clk_in);
		req_in <= 1'b1;
		write_in <= w;
		keep_oe_in <= k;
		addr_in <= a;
		wdata_in <= d;
		if (w) ref_m[a] = d;
		else exp_q.push_back(ref_m[a]);
		@(posedge sys_clk_in);
		req_in <= 1'b0;
		@(posedge sys_clk_in);
		#1;
	endtask
	initial begin
		#200000;
		mismatches++;
		give_verdict();
	end
	initial begin
		logic [20:0] a [8];
		void'($urandom(83289));
		for (int r = 0; r < 2; r++) begin
			reset_in <= 1'b1;
			repeat (5) @(posedge sys_clk_in);
			reset_in <= 1'b0;
			foreach (a[i]) a[i] = (i == 0) ? 21'h1FFFFF : (i == 1) ? 21'h000000 : 21'($urandom);
			foreach (a[i]) access(1'b1, 1'($urandom), a[i], 8'($urandom));
			for (int i = 7; i >= 0; i--) access(1'b0, 1'($urandom), a[i], 8'h00);
			repeat (30) @(posedge sys_clk_in);
			$display("test %0d done", r);
		end
		give_verdict();
	end
endmodule // sram_host_ctrl_tb_top
`default_nettype wire
